// ==== verilog/external_interrupt_sensitivity.sv ====
// External interrupt sensitivity control with APB registers
//
// Added by the designer: the APB slave port.
module external_interrupt_sensitivity
	import ext_irq_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Port pins, asynchronous
	input  wire logic [7:0]  port_a_pins,
	input  wire logic [5:0]  port_b_pins,
	input  wire logic [2:1]  port_c_pins,
	input  wire logic [7:0]  port_d_pins,
	input  wire logic        priority_pin,
	// Per pin interrupt enables from port logic
	input  wire logic [7:0]  port_a_irq_en,
	input  wire logic [5:0]  port_b_irq_en,
	input  wire logic [2:1]  port_c_irq_en,
	input  wire logic [7:0]  port_d_irq_en,
	// Processor core
	input  wire logic        irq_mask_high_bit,
	input  wire logic        irq_mask_low_bit,
	input  wire logic        halt_auto_wakeup,
	input  wire logic [3:0]  group_ack,
	input  wire logic        priority_ack,
	// Requests to the nested controller
	output logic             ext_source_group0,
	output logic             ext_source_group1,
	output logic             ext_source_group2,
	output logic             ext_source_group3,
	output logic             vector2_request,
	output logic             priority_pin_interrupt,
	output logic             irq
);

	// Top level state; the group detectors keep their own
	typedef struct packed {
		logic [32:0] sync1;   // First synchroniser stage
		logic [32:0] sync2;   // Second synchroniser stage
		logic [7:0]  sens;    // Group trigger fields
		logic        tl_sel;  // Priority pin edge
		logic        tl_en;   // Priority pin enable
		logic        tl_prev; // Last priority pin level
		logic        tl_pend; // Priority pin request
		logic [3:0]  reqp;    // Last group requests
		logic [4:0]  status;  // Sticky event flags
		logic [4:0]  mask;    // Interrupt mask
		logic [31:0] rdata;   // Read data
	} top_state_type;

	top_state_type s_q;
	top_state_type s_d;

	group_if gif [GROUPS] ();

	logic [32:0] raw;          // Pins as gathered per group
	logic [31:0] raw_en;       // Enables as gathered per group
	logic        lvl3;         // Interrupts disabled at level 3
	logic        setup;        // APB setup cycle
	logic        access;       // APB access cycle
	logic        hit;          // Mapped address
	logic        wr_sens;      // Write to trigger fields
	logic        wr_sens_ok;   // Such a write is allowed
	logic        wr_top;       // Write to top level control
	logic        rd_stat;      // Completed status read
	logic        wr_mask;      // Write to mask
	logic [3:0]  req;          // Group requests
	logic [3:0]  change;       // Field changed by a write
	logic        tl_pin;       // Synchronised priority pin
	logic        tl_evt;       // Selected priority pin edge
	logic        tl_spur;      // Request on disable
	logic [4:0]  set;          // New status events
	logic [31:0] rmux;         // Read multiplexer

	// Gather pins and enables into fixed eight bit slots
	assign raw = {priority_pin,
		port_d_pins,
		5'h1F, port_c_pins, 1'b1,
		2'h3, port_b_pins,
		port_a_pins};
	assign raw_en = {port_d_irq_en,
		5'h00, port_c_irq_en, 1'b0,
		2'h0, port_b_irq_en,
		port_a_irq_en};

	// Level 3 needs both mask bits set
	assign lvl3 = irq_mask_high_bit & irq_mask_low_bit;

	// APB decode
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign hit     = (paddr == ADDR_SENS) | (paddr == ADDR_TOP) |
		(paddr == ADDR_STATUS) | (paddr == ADDR_MASK);
	assign wr_sens = access & pwrite & pstrb[0] & (paddr == ADDR_SENS);
	// Writes outside level 3 are dropped silently
	assign wr_sens_ok = wr_sens & lvl3;
	assign wr_top  = access & pwrite & pstrb[0] & (paddr == ADDR_TOP);
	assign wr_mask = access & pwrite & pstrb[0] & (paddr == ADDR_MASK);
	assign rd_stat = access & ~pwrite & (paddr == ADDR_STATUS);

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = access;
	assign pslverr = access & ~hit;
	assign prdata  = s_q.rdata;

	// One detector per group
	for (genvar g = 0; g < GROUPS; g++) begin : grp
		assign gif[g].pins   = s_q.sync2[8*g +: 8];
		assign gif[g].pin_en = raw_en[8*g +: 8] & GROUP_PINS[g];
		assign gif[g].sel    = s_q.sens[SEL_W*g +: SEL_W];
		// A different value written clears what was pending
		assign change[g] = wr_sens_ok &
			(pwdata[SEL_W*g +: SEL_W] != s_q.sens[SEL_W*g +: SEL_W]);
		assign gif[g].clr = group_ack[g] | change[g];
		assign req[g] = gif[g].req;

		group_detect u_det (
			.pclk    (pclk),
			.presetn (presetn),
			.gi      (gif[g])
		);
	end

	// Priority pin edge detection
	assign tl_pin = s_q.sync2[32];
	assign tl_evt = s_q.tl_en &
		(s_q.tl_sel ? (tl_pin & ~s_q.tl_prev) : (~tl_pin & s_q.tl_prev));
	// Dropping the enable while the pin rests past its edge fires once
	assign tl_spur = wr_top & s_q.tl_en & ~pwdata[TOP_EN_BIT] &
		(tl_pin == s_q.tl_sel);

	// Status events: a rising group request or a new priority request
	assign set = {tl_evt | tl_spur, req & ~s_q.reqp};

	// Read multiplexer; reserved bits read as zero
	always_comb begin
		case (paddr)
			ADDR_SENS:   rmux = {24'h000000, s_q.sens};
			ADDR_TOP:    rmux = {30'h00000000, s_q.tl_sel, s_q.tl_en};
			ADDR_STATUS: rmux = {27'h0000000, s_q.status};
			ADDR_MASK:   rmux = {27'h0000000, s_q.mask};
			default:     rmux = 32'h00000000;
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		// Two stage synchroniser, second stage alone is read
		s_d.sync1   = raw;
		s_d.sync2   = s_q.sync1;
		s_d.tl_prev = tl_pin;
		s_d.reqp    = req;
		// Trigger fields
		if (wr_sens_ok) begin
			s_d.sens = pwdata[7:0];
		end
		// Top level control
		if (wr_top) begin
			s_d.tl_en = pwdata[TOP_EN_BIT];
			if (!s_q.tl_en) begin
				s_d.tl_sel = pwdata[TOP_SEL_BIT];
			end
		end
		// Priority request, a new edge beats the acknowledge
		s_d.tl_pend = tl_evt | tl_spur | (s_q.tl_pend & ~priority_ack);
		// Mask register
		if (wr_mask) begin
			s_d.mask = pwdata[4:0];
		end
		// Only flags already returned are cleared, so a late event survives
		s_d.status = set | (s_q.status & ~(rd_stat ? s_q.rdata[4:0] : 5'h00));
		// Read data captured in the setup cycle
		if (setup && !pwrite) begin
			s_d.rdata = rmux;
		end
	end

	// State register; synchronisers idle high like pulled-up pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.sync1   <= {33{1'b1}};
			s_q.sync2   <= {33{1'b1}};
			s_q.sens    <= RST_SENS;
			s_q.tl_sel  <= RST_TOP[TOP_SEL_BIT];
			s_q.tl_en   <= RST_TOP[TOP_EN_BIT];
			s_q.tl_prev <= 1'b1;
			s_q.tl_pend <= 1'b0;
			s_q.reqp    <= 4'h0;
			s_q.status  <= RST_FLAG;
			s_q.mask    <= RST_FLAG;
			s_q.rdata   <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end

	// Requests toward the nested controller
	assign ext_source_group0 = req[0];
	assign ext_source_group1 = req[1];
	assign ext_source_group2 = req[2];
	assign ext_source_group3 = req[3];
	// Group zero and halt wake-up share vector VEC_GROUP0
	assign vector2_request = req[0] | halt_auto_wakeup;
	assign priority_pin_interrupt = s_q.tl_pend;
	assign irq = |(s_q.status & s_q.mask);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Field write outside level 3 leaves the fields alone
	property p_sens_locked;
		wr_sens && !lvl3 |=> $stable(s_q.sens);
	endproperty
	a_sens_locked: assert property (p_sens_locked) else $error("field changed outside level 3");

	// Field write at level 3 stores the byte
	property p_sens_write;
		wr_sens && lvl3 |=> s_q.sens == $past(pwdata[7:0]);
	endproperty
	a_sens_write: assert property (p_sens_write) else $error("field write lost");

	// Edge select frozen while enabled
	property p_sel_locked;
		wr_top && s_q.tl_en |=> $stable(s_q.tl_sel);
	endproperty
	a_sel_locked: assert property (p_sel_locked) else $error("edge select changed while enabled");

	// Enable follows the written bit
	property p_en_write;
		wr_top |=> s_q.tl_en == $past(pwdata[0]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable write lost");

	// Falling edge selected and seen raises the request
	property p_tl_fall;
		s_q.tl_en && !s_q.tl_sel && s_q.tl_prev && !tl_pin |=> s_q.tl_pend;
	endproperty
	a_tl_fall: assert property (p_tl_fall) else $error("falling edge missed");

	// Disabling with the pin at its resting level fires
	property p_spurious;
		wr_top && s_q.tl_en && !pwdata[0] && (tl_pin == s_q.tl_sel) |=> s_q.tl_pend;
	endproperty
	a_spurious: assert property (p_spurious) else $error("disable request missing");

endmodule

// ==== verilog/ext_irq_pkg.sv ====
// Constants and types shared by the external interrupt sensitivity block
// How it works
// - Four groups, each with its own trigger
// - Codes: 00 fall+low, 01 rise, 10 fall, 11 both
// - Group fields at bits 7:6, 5:4, 3:2, 1:0
// - Trigger fields written only at mask level 3
// - Changing a group's field clears its pending
// - Both control registers read/write, reset to zero
// - Bit 1 picks priority pin edge: 0 fall
// - Edge bit writable only while enable is clear
// - Bit 0 enables the priority pin interrupt
// - Clearing enable may raise a spurious request
// - Groups gather ports A, B, C, D pins
// - Level 3 means both mask bits are one
// - Group zero shares vector two with wake-up
package ext_irq_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_SENS   = 10'h029;
	localparam logic [9:0]  IDX_TOP    = 10'h02A;
	localparam logic [9:0]  IDX_STATUS = 10'h02B;
	localparam logic [9:0]  IDX_MASK   = 10'h02C;
	localparam logic [11:0] ADDR_SENS   = {IDX_SENS, 2'b00};
	localparam logic [11:0] ADDR_TOP    = {IDX_TOP, 2'b00};
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [11:0] ADDR_MASK   = {IDX_MASK, 2'b00};

	// Reset values
	localparam logic [7:0]  RST_SENS = 8'h00;
	localparam logic [7:0]  RST_TOP  = 8'h00;
	localparam logic [4:0]  RST_FLAG = 5'h00;

	// Field positions in the top level control register
	localparam int TOP_EN_BIT  = 0;
	localparam int TOP_SEL_BIT = 1;

	// Field width and count of groups
	localparam int GROUPS    = 4;
	localparam int SEL_W     = 2;
	localparam int STAT_PRIO = 4;

	// Pins present in each group, one bit per pin slot
	localparam logic [7:0] GROUP_PINS [GROUPS] = '{8'hFF, 8'h3F, 8'h06, 8'hD3};

	// Vector that serves group zero and halt wake-up
	localparam logic [3:0] VEC_GROUP0 = 4'h2;

	// Trigger codes of a group field
	typedef enum logic [1:0] {
		TRIG_FALL_LOW = 2'b00,
		TRIG_RISE     = 2'b01,
		TRIG_FALL     = 2'b10,
		TRIG_BOTH     = 2'b11
	} trig_type;

endpackage

// ==== verilog/group_if.sv ====
// Interface between the top and one group detector
interface group_if;
	logic [7:0] pins;    // Synchronised pin levels
	logic [7:0] pin_en;  // Pins enabled for interrupts
	logic [1:0] sel;     // Trigger code
	logic       clr;     // Clear pending pulse
	logic       req;     // Request toward the controller
	logic       evt;     // Selected event seen this cycle

	modport ctrl (output pins, output pin_en, output sel, output clr, input req, input evt);
	modport det  (input pins, input pin_en, input sel, input clr, output req, output evt);
endinterface

// ==== verilog/group_detect.sv ====
// Edge and level detector for one external interrupt group
module group_detect
	import ext_irq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Group link
	group_if.det     gi
);

	// Detector state
	typedef struct packed {
		logic [7:0] prev;  // Last pin levels
		logic       pend;  // Latched request
	} det_state_type;

	det_state_type s_q;
	det_state_type s_d;
	logic [7:0]    fall;  // Falling edges on enabled pins
	logic [7:0]    rise;  // Rising edges on enabled pins
	logic          low;   // Some enabled pin low

	// Edge finding and trigger selection
	always_comb begin
		s_d      = s_q;
		fall     = s_q.prev & ~gi.pins & gi.pin_en;
		rise     = ~s_q.prev & gi.pins & gi.pin_en;
		low      = |(~gi.pins & gi.pin_en);
		s_d.prev = gi.pins;
		case (trig_type'(gi.sel))
			TRIG_FALL_LOW: gi.evt = |fall;
			TRIG_RISE:     gi.evt = |rise;
			TRIG_FALL:     gi.evt = |fall;
			TRIG_BOTH:     gi.evt = |(fall | rise);
			default:       gi.evt = 1'b0;
		endcase
		// A new event beats a clear in the same cycle
		s_d.pend = gi.evt | (s_q.pend & ~gi.clr);
		// Level mode holds the request while a pin sits low
		gi.req = s_q.pend | ((gi.sel == TRIG_FALL_LOW) & low);
	end

	// State register; prev idles high like a pulled-up pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{prev: 8'hFF, pend: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Rising edge in rise mode latches pending
	property p_rise_mode;
		(gi.sel == TRIG_RISE) && (|(~s_q.prev & gi.pins & gi.pin_en)) |=> s_q.pend;
	endproperty
	a_rise_mode: assert property (p_rise_mode) else $error("rise not latched");

	// Clear with no new event drops pending
	property p_clear;
		gi.clr && !gi.evt |=> !s_q.pend;
	endproperty
	a_clear: assert property (p_clear) else $error("pending not cleared");

	// Disabled pins never raise pending
	property p_pin_gate;
		(gi.pin_en == 8'h00) && !s_q.pend |=> !s_q.pend;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("disabled pins set pending");

endmodule

// ==== verification/pin_partner.sv ====
// Partner model: port pins and processor core around the block
module pin_partner (
	// Clock
	input  wire logic       pclk,
	// Port pins, idle high as with pull-ups
	output logic      [7:0] port_a_pins,
	output logic      [5:0] port_b_pins,
	output logic      [2:1] port_c_pins,
	output logic      [7:0] port_d_pins,
	output logic            priority_pin,
	// Pin interrupt enables
	output logic      [7:0] port_a_irq_en,
	output logic      [5:0] port_b_irq_en,
	output logic      [2:1] port_c_irq_en,
	output logic      [7:0] port_d_irq_en,
	// Core side
	output logic            irq_mask_high_bit,
	output logic            irq_mask_low_bit,
	output logic            halt_auto_wakeup,
	output logic      [3:0] group_ack,
	output logic            priority_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle state: pins high, every pin enabled, interrupts masked
	initial begin
		{port_a_pins, port_b_pins, port_c_pins, port_d_pins} = '1;
		priority_pin = 1'b1;
		{port_a_irq_en, port_b_irq_en, port_c_irq_en, port_d_irq_en} = '1;
		{irq_mask_high_bit, irq_mask_low_bit} = 2'b11;
		halt_auto_wakeup = 1'b0;
		group_ack = 4'h0;
		priority_ack = 1'b0;
	end

	// Pin moves land just after an edge, never on it
	task automatic pin_a(input int i, input logic v);
		@(posedge pclk);
		port_a_pins[i] <= v;
	endtask

	task automatic pin_pri(input logic v);
		@(posedge pclk);
		priority_pin <= v;
	endtask

	// Any pin of any group, with its interrupt enable
	task automatic pin_set(input int g, input int i, input logic v, input logic en);
		@(posedge pclk);
		case (g)
			0: begin
				port_a_pins[i] <= v;
				port_a_irq_en[i] <= en;
			end
			1: begin
				port_b_pins[i] <= v;
				port_b_irq_en[i] <= en;
			end
			2: begin
				port_c_pins[i] <= v;
				port_c_irq_en[i] <= en;
			end
			default: begin
				port_d_pins[i] <= v;
				port_d_irq_en[i] <= en;
			end
		endcase
	endtask

	// Mask level; software raises level 3 before touching triggers
	task automatic core(input logic lvl3, input logic wake);
		@(posedge pclk);
		{irq_mask_high_bit, irq_mask_low_bit} <= {lvl3, 1'b1};
		halt_auto_wakeup <= wake;
	endtask

	// One-cycle acknowledge pulses, as the controller gives them
	task automatic ack(input logic [3:0] g, input logic p);
		@(posedge pclk);
		group_ack <= g;
		priority_ack <= p;
		@(posedge pclk);
		group_ack <= 4'h0;
		priority_ack <= 1'b0;
	endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the external interrupt sensitivity block
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench import ext_irq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite;      // Bus drive
	logic [11:0] paddr;                                     // Byte address
	logic [31:0] pwdata, prdata, rd;                        // Data
	logic        pready, pslverr, er;                       // Answer
	logic [7:0]  port_a_pins, port_d_pins, port_a_irq_en, port_d_irq_en;
	logic [5:0]  port_b_pins, port_b_irq_en;
	logic [2:1]  port_c_pins, port_c_irq_en;
	logic        priority_pin, irq_mask_high_bit, irq_mask_low_bit, halt_auto_wakeup;
	logic [3:0]  group_ack;
	logic        priority_ack, vector2_request, priority_pin_interrupt, irq;
	logic        ext_source_group0, ext_source_group1, ext_source_group2, ext_source_group3;
	logic [7:0]  exp_sens, exp_top, exp_mask, rv;           // Register model
	int          bad_count, n_tests, t;                     // Counters

	external_interrupt_sensitivity external_interrupt_sensitivity_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .port_a_pins, .port_b_pins, .port_c_pins, .port_d_pins, .priority_pin,
		.port_a_irq_en, .port_b_irq_en, .port_c_irq_en, .port_d_irq_en, .irq_mask_high_bit,
		.irq_mask_low_bit, .halt_auto_wakeup, .group_ack, .priority_ack, .ext_source_group0,
		.ext_source_group1, .ext_source_group2, .ext_source_group3, .vector2_request,
		.priority_pin_interrupt, .irq);
	pin_partner pin_partner_i (.pclk, .port_a_pins, .port_b_pins, .port_c_pins,
		.port_d_pins, .priority_pin, .port_a_irq_en, .port_b_irq_en, .port_c_irq_en,
		.port_d_irq_en, .irq_mask_high_bit, .irq_mask_low_bit, .halt_auto_wakeup,
		.group_ack, .priority_ack);

	// Free-running bus clock, 8 ns
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Expected request of group zero for a trigger code and a pin move
	function automatic logic exp_req(int m, logic o, logic n);
		logic fall, rise;
		fall = o & ~n;
		rise = ~o & n;
		return (m == 1) ? rise : (m == 3) ? (fall | rise) : fall;
	endfunction

	// One bus transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) bad_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, update the model, read back and compare
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
		if (a == ADDR_SENS) begin
			if (irq_mask_high_bit && irq_mask_low_bit) exp_sens = d;
		end else if (a == ADDR_TOP) begin
			exp_top = exp_top[0] ? {6'h0, exp_top[1], d[0]} : {6'h0, d[1:0]};
		end else begin
			exp_mask = d & 8'h1F;
		end
		apb(1'b0, a, 32'h0, r, e);
		`CHK("reg", {24'h0, (a == ADDR_SENS) ? exp_sens : (a == ADDR_TOP) ? exp_top : exp_mask}, r)
	endtask

	// Closing report and verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{exp_top, exp_mask} = '0;
		presetn = 1'b0;
		void'($urandom(20839));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped place
		apb(1'b0, ADDR_SENS, 32'h0, rd, er);
		`CHK("sens rst", {24'h0, RST_SENS}, rd)
		apb(1'b0, ADDR_TOP, 32'h0, rd, er);
		`CHK("top rst", {24'h0, RST_TOP}, rd)
		apb(1'b0, 12'h000, 32'h0, rd, er);
		`CHK("slverr", 1'b1, er)
		$display("end test %0d", t++);
		// Random trigger fields, then a refused write below level 3
		rv = 8'($urandom());
		wr(ADDR_SENS, rv);
		pin_partner_i.core(1'b0, 1'b0);
		wr(ADDR_SENS, ~rv);
		pin_partner_i.core(1'b1, 1'b1);
		repeat (2) @(posedge pclk);
		`CHK("vec2", 1'b1, vector2_request)
		pin_partner_i.core(1'b1, 1'b0);
		wr(ADDR_SENS, 8'h00);
		$display("end test %0d", t++);
		// Every trigger code on group zero; a field change drops pending
		for (int m = 0; m < 4; m++) begin
			pin_partner_i.pin_a(0, 1'b0);
			repeat (5) @(posedge pclk);
			`CHK("fall", exp_req(m, 1'b1, 1'b0), ext_source_group0)
			`CHK("g1", 1'b0, ext_source_group1)
			pin_partner_i.ack(4'h1, 1'b0);
			repeat (2) @(posedge pclk);
			`CHK("low lvl", logic'(m == 0), ext_source_group0)
			pin_partner_i.pin_a(0, 1'b1);
			repeat (5) @(posedge pclk);
			`CHK("rise", exp_req(m, 1'b0, 1'b1), ext_source_group0)
			wr(ADDR_SENS, 8'((m + 1) % 4));
			`CHK("cleared", 1'b0, ext_source_group0)
		end
		$display("end test %0d", t++);
		// Interrupt raised, cleared by status read
		wr(ADDR_MASK, 8'h01);
		apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
		pin_partner_i.pin_a(0, 1'b0);
		repeat (5) @(posedge pclk);
		`CHK("irq on", 1'b1, irq)
		apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
		`CHK("status", 32'h1, rd)
		// The status clear lands on the access edge, so look one edge later
		@(posedge pclk);
		`CHK("irq off", 1'b0, irq)
		pin_partner_i.pin_a(0, 1'b1);
		pin_partner_i.ack(4'h1, 1'b0);
		$display("end test %0d", t++);
		// Priority pin: edge select locked while enabled
		wr(ADDR_TOP, 8'h02);
		wr(ADDR_TOP, 8'h03);
		wr(ADDR_TOP, 8'h01);
		pin_partner_i.pin_pri(1'b0);
		repeat (5) @(posedge pclk);
		`CHK("pri fall", 1'b0, priority_pin_interrupt)
		pin_partner_i.pin_pri(1'b1);
		repeat (5) @(posedge pclk);
		`CHK("pri rise", 1'b1, priority_pin_interrupt)
		pin_partner_i.ack(4'h0, 1'b1);
		repeat (2) @(posedge pclk);
		`CHK("pri ack", 1'b0, priority_pin_interrupt)
		wr(ADDR_TOP, 8'h02);
		repeat (2) @(posedge pclk);
		`CHK("spurious", 1'b1, priority_pin_interrupt)
		wr(ADDR_MASK, 8'h10);
		`CHK("pri irq", 1'b1, irq)
		apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
		`CHK("pri stat", 32'h10, rd)
		$display("end test %0d", t++);
		// Falling edges on groups one to three; absent and disabled pins stay quiet
		wr(ADDR_SENS, 8'hAA);
		pin_partner_i.pin_set(3, 5, 1'b0, 1'b1);
		pin_partner_i.pin_set(1, 0, 1'b0, 1'b0);
		repeat (5) @(posedge pclk);
		`CHK("absent", 1'b0, ext_source_group3)
		`CHK("pin off", 1'b0, ext_source_group1)
		pin_partner_i.pin_set(1, 5, 1'b0, 1'b1);
		pin_partner_i.pin_set(2, 2, 1'b0, 1'b1);
		pin_partner_i.pin_set(3, 7, 1'b0, 1'b1);
		repeat (5) @(posedge pclk);
		`CHK("g1 fall", 1'b1, ext_source_group1)
		`CHK("g2 fall", 1'b1, ext_source_group2)
		`CHK("g3 fall", 1'b1, ext_source_group3)
		`CHK("g0 quiet", 1'b0, ext_source_group0)
		$display("end test %0d", t++);
		print_verdict();
	end
endmodule
